// file: rtl/parallel_byte_input_port.sv
// parallel byte input port with axi4-lite control and status
//
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module parallel_byte_input_port (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// host pins
	input wire logic i_strobe_n,
	input wire logic [7:0] i_data,
	output par_port_pkg::port_pins_t o_pins,
	// fault sensors
	input wire logic [par_port_pkg::FAULT_W-1:0] i_fault,
	// interrupt
	output logic o_irq,
	// axi4-lite write address
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [4:0] i_awaddr,
	// axi4-lite write data
	input wire logic i_wvalid,
	output logic o_wready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	// axi4-lite write response
	output logic o_bvalid,
	input wire logic i_bready,
	output logic [1:0] o_bresp,
	// axi4-lite read address
	input wire logic i_arvalid,
	output logic o_arready,
	input wire logic [4:0] i_araddr,
	// axi4-lite read data
	output logic o_rvalid,
	input wire logic i_rready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp
);
	import par_port_pkg::*;

	typedef enum {ST_IDLE, ST_BUSY, ST_ACK} port_state_t;

	typedef struct packed {
		port_state_t fsm;
		logic [ACK_CNT_W-1:0] ack_cnt;
		port_pins_t pins;
		logic [3:0] ctrl;
		logic [FAULT_W-1:0] f_meta;
		logic [FAULT_W-1:0] f_sync;
		logic [IRQ_W-1:0] irq_stat;
		logic [IRQ_W-1:0] irq_en;
		logic irq;
		logic aw_held;
		logic [4:0] awaddr;
		logic w_held;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} top_state_t;

	localparam logic [ACK_CNT_W-1:0] ACK_LAST = ACK_CNT_W'(ACK_CYCLES - 1);

	top_state_t s_r;
	top_state_t s_nxt;
	logic take;
	logic lost;
	logic [7:0] rx_byte;
	logic [IRQ_W-1:0] irq_set;
	logic [IRQ_W-1:0] irq_clr;
	logic paper_bad;
	logic other_bad;
	logic done_pulse;
	logic wr_go;
	logic rd_go;

	strobe_capture strobe_capture_i (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_strobe_n(i_strobe_n),
		.i_data(i_data),
		.i_busy(s_r.pins.busy),
		.o_take(take),
		.o_lost(lost),
		.o_byte(rx_byte)
	);

	always_comb begin
		s_nxt = s_r;
		irq_set = '0;
		irq_clr = '0;
		done_pulse = 1'b0;
		// fault sensors are asynchronous, two flops first
		s_nxt.f_meta = i_fault;
		s_nxt.f_sync = s_r.f_meta;

		// write channel: address and data accepted in either order
		wr_go = s_r.aw_held && s_r.w_held && !s_r.bvalid;
		if (i_awvalid && !s_r.aw_held) begin
			s_nxt.aw_held = 1'b1;
			s_nxt.awaddr = i_awaddr;
		end
		if (i_wvalid && !s_r.w_held) begin
			s_nxt.w_held = 1'b1;
			s_nxt.wdata = i_wdata;
			s_nxt.wstrb = i_wstrb;
		end
		if (wr_go) begin
			s_nxt.aw_held = 1'b0;
			s_nxt.w_held = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = RESP_OKAY;
			if (!s_r.awaddr[BANK_BIT]) begin
				if (s_r.awaddr[3:0] == ADDR_CTRL) begin
					if (s_r.wstrb[0]) begin
						s_nxt.ctrl = s_r.wdata[3:0];
						done_pulse = s_r.wdata[CTRL_DONE];
					end
					s_nxt.ctrl[CTRL_DONE] = 1'b0;
				end else begin
					s_nxt.bresp = RESP_SLVERR;
				end
			end else if (s_r.awaddr[3:0] == ADDR_IRQ_CLR) begin
				if (s_r.wstrb[0]) begin
					irq_clr = s_r.wdata[IRQ_W-1:0];
				end
			end else if (s_r.awaddr[3:0] == ADDR_IRQ_EN) begin
				if (s_r.wstrb[0]) begin
					s_nxt.irq_en = s_r.wdata[IRQ_W-1:0];
				end
			end else begin
				s_nxt.bresp = RESP_SLVERR;
			end
		end
		if (s_r.bvalid && i_bready) begin
			s_nxt.bvalid = 1'b0;
		end

		// read channel
		rd_go = i_arvalid && !s_r.rvalid;
		if (rd_go) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = RESP_OKAY;
			s_nxt.rdata = ZERO32;
			if (!i_araddr[BANK_BIT]) begin
				case (i_araddr[3:0])
					ADDR_CTRL: s_nxt.rdata[3:0] = s_r.ctrl;
					ADDR_STAT: s_nxt.rdata[5:0] = s_r.pins;
					ADDR_DATA: s_nxt.rdata[7:0] = rx_byte;
					ADDR_FAULT: s_nxt.rdata[FAULT_W-1:0] = s_r.f_sync;
					default: s_nxt.rresp = RESP_SLVERR;
				endcase
			end else begin
				case (i_araddr[3:0])
					ADDR_IRQ_STAT: s_nxt.rdata[IRQ_W-1:0] = s_r.irq_stat;
					ADDR_IRQ_EN: s_nxt.rdata[IRQ_W-1:0] = s_r.irq_en;
					default: s_nxt.rresp = RESP_SLVERR;
				endcase
			end
		end
		if (s_r.rvalid && i_rready) begin
			s_nxt.rvalid = 1'b0;
		end

		// handshake machine
		case (s_r.fsm)
			ST_IDLE: begin
				if (take) begin
					s_nxt.pins.busy = 1'b1;
					s_nxt.fsm = ST_BUSY;
				end
			end
			ST_BUSY: begin
				// busy holds until software reports the byte consumed
				if (done_pulse) begin
					s_nxt.pins.busy = 1'b0;
					s_nxt.pins.ack_n = 1'b0;
					s_nxt.ack_cnt = '0;
					s_nxt.fsm = ST_ACK;
				end
			end
			ST_ACK: begin
				// a strobe edge during the pulse is accepted as busy is already low
				if (s_r.ack_cnt == ACK_LAST) begin
					s_nxt.pins.ack_n = 1'b1;
					s_nxt.fsm = take ? ST_BUSY : ST_IDLE;
				end else begin
					s_nxt.ack_cnt = s_r.ack_cnt + 1'b1;
					s_nxt.fsm = take ? ST_BUSY : ST_ACK;
				end
				if (take) begin
					s_nxt.pins.busy = 1'b1;
					s_nxt.pins.ack_n = 1'b1;
				end
			end
			default: s_nxt.fsm = ST_IDLE;
		endcase

		// status lines
		paper_bad = s_r.f_sync[F_NO_PAPER] | s_r.f_sync[F_HEAD_UP]
			| (s_r.f_sync[F_NEAR_END] & s_r.ctrl[CTRL_NEAR_EN]);
		other_bad = s_r.f_sync[F_TEMP] | s_r.f_sync[F_CUTTER] | s_r.f_sync[F_VOLT]
			| s_r.f_sync[F_HW] | s_r.f_sync[F_MARK];
		s_nxt.pins.paper_err = paper_bad;
		s_nxt.pins.err_n = ~other_bad;
		// software encodes the exact fault class on the extra pair
		s_nxt.pins.extra_status_line_one = s_r.ctrl[CTRL_LINE_ONE];
		s_nxt.pins.extra_status_line_two = s_r.ctrl[CTRL_LINE_TWO];

		// interrupts: set beats a clear in the same cycle
		irq_set[IRQ_BYTE] = take;
		irq_set[IRQ_LOST] = lost;
		s_nxt.irq_stat = (s_r.irq_stat & ~irq_clr) | irq_set;
		s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_en);
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_r <= '{fsm: ST_IDLE, ack_cnt: '0, pins: PINS_RST, ctrl: 4'h0,
				f_meta: '0, f_sync: '0, irq_stat: '0, irq_en: '0, irq: 1'b0,
				aw_held: 1'b0, awaddr: 5'h00, w_held: 1'b0, wdata: ZERO32,
				wstrb: 4'h0, bvalid: 1'b0, bresp: RESP_OKAY, rvalid: 1'b0,
				rdata: ZERO32, rresp: RESP_OKAY};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_pins = s_r.pins;
	assign o_irq = s_r.irq;
	assign o_awready = ~s_r.aw_held;
	assign o_wready = ~s_r.w_held;
	assign o_bvalid = s_r.bvalid;
	assign o_bresp = s_r.bresp;
	assign o_arready = ~s_r.rvalid;
	assign o_rvalid = s_r.rvalid;
	assign o_rdata = s_r.rdata;
	assign o_rresp = s_r.rresp;
endmodule
`default_nettype wire

// file: pkg/par_port_pkg.sv
// package: register map, field layout and timing constants for the parallel byte input port
package par_port_pkg;
	// clock and timing
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned ACK_PULSE_NS = 5000;
	localparam int unsigned ACK_CYCLES = (ACK_PULSE_NS * (CLK_HZ / 1_000_000)) / 1000;
	localparam int unsigned ACK_CNT_W = 8;

	// register byte addresses
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STAT = 4'h4;
	localparam logic [3:0] ADDR_DATA = 4'h8;
	localparam logic [3:0] ADDR_FAULT = 4'hc;
	localparam logic [3:0] ADDR_IRQ_STAT = 4'h0;
	localparam logic [3:0] ADDR_IRQ_CLR = 4'h4;
	localparam logic [3:0] ADDR_IRQ_EN = 4'h8;
	localparam int unsigned BANK_BIT = 4;

	// ctrl fields
	localparam int unsigned CTRL_NEAR_EN = 0;
	localparam int unsigned CTRL_DONE = 1;
	localparam int unsigned CTRL_LINE_ONE = 2;
	localparam int unsigned CTRL_LINE_TWO = 3;
	// fault fields
	localparam int unsigned F_NO_PAPER = 0;
	localparam int unsigned F_HEAD_UP = 1;
	localparam int unsigned F_NEAR_END = 2;
	localparam int unsigned F_TEMP = 3;
	localparam int unsigned F_CUTTER = 4;
	localparam int unsigned F_VOLT = 5;
	localparam int unsigned F_HW = 6;
	localparam int unsigned F_MARK = 7;
	localparam int unsigned FAULT_W = 8;
	// irq fields
	localparam int unsigned IRQ_BYTE = 0;
	localparam int unsigned IRQ_LOST = 1;
	localparam int unsigned IRQ_W = 2;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [31:0] ZERO32 = 32'h0000_0000;

	// host-facing pin bundle
	typedef struct packed {
		logic ack_n;
		logic busy;
		logic paper_err;
		logic err_n;
		logic extra_status_line_one;
		logic extra_status_line_two;
	} port_pins_t;
	localparam port_pins_t PINS_RST = '{ack_n: 1'b1, busy: 1'b0, paper_err: 1'b0,
		err_n: 1'b1, extra_status_line_one: 1'b0, extra_status_line_two: 1'b0};
endpackage

// file: rtl/strobe_capture.sv
// strobe synchroniser, falling-edge detector and data latch
`timescale 1ns/10ps
`default_nettype none
module strobe_capture (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// pins
	input wire logic i_strobe_n,
	input wire logic [7:0] i_data,
	// control
	input wire logic i_busy,
	// capture result
	output logic o_take,
	output logic o_lost,
	output logic [7:0] o_byte
);
	import par_port_pkg::*;

	typedef struct packed {
		logic [1:0] stb_sync;
		logic stb_prev;
		logic [7:0] d_meta;
		logic [7:0] d_sync;
		logic take;
		logic lost;
		logic [7:0] byte_r;
	} cap_state_t;

	cap_state_t s_r;
	cap_state_t s_nxt;
	logic fall;

	always_comb begin
		s_nxt = s_r;
		// strobe goes through two flops before the edge detector
		s_nxt.stb_sync = {s_r.stb_sync[0], i_strobe_n};
		s_nxt.stb_prev = s_r.stb_sync[1];
		s_nxt.d_meta = i_data;
		s_nxt.d_sync = s_r.d_meta;
		fall = s_r.stb_prev & ~s_r.stb_sync[1];
		s_nxt.take = 1'b0;
		s_nxt.lost = 1'b0;
		if (fall && !i_busy) begin
			// data path delayed equally with strobe, so setup holds; bit0 is lsb
			s_nxt.byte_r = s_r.d_sync;
			s_nxt.take = 1'b1;
		end else if (fall) begin
			s_nxt.lost = 1'b1; // edge while busy is dropped
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_r <= '{stb_sync: 2'b11, stb_prev: 1'b1, d_meta: 8'h00, d_sync: 8'h00,
				take: 1'b0, lost: 1'b0, byte_r: 8'h00};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_take = s_r.take;
	assign o_lost = s_r.lost;
	assign o_byte = s_r.byte_r;
endmodule
`default_nettype wire

// file: test/par_port_chk.sv
// checker: pin-level assertions for the parallel byte input port
`timescale 1ns/10ps
`default_nettype none
module par_port_chk (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// watched pins
	input wire logic i_strobe_n,
	input wire logic [par_port_pkg::FAULT_W-1:0] i_fault,
	input wire par_port_pkg::port_pins_t o_pins
);
	import par_port_pkg::*;
	// cycles the acknowledge has been low so far
	logic [7:0] low_r;
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			low_r <= 8'h00;
		end else begin
			low_r <= o_pins.ack_n ? 8'h00 : low_r + 8'h01;
		end
	end
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	property p_busy_rise;
		$rose(o_pins.busy) |-> $past(i_strobe_n, 2) == 1'b0;
	endproperty
	a_busy_rise: assert property (p_busy_rise) else $error("busy rose with no strobe");
	property p_busy_fall;
		$fell(o_pins.busy) |-> !o_pins.ack_n;
	endproperty
	a_busy_fall: assert property (p_busy_fall) else $error("busy fell with no ack");
	property p_ack_ready;
		$fell(o_pins.ack_n) |-> $fell(o_pins.busy);
	endproperty
	a_ack_ready: assert property (p_ack_ready) else $error("ack while not ready");
	property p_ack_len;
		$rose(o_pins.ack_n) |-> (low_r == ACK_CYCLES) || o_pins.busy;
	endproperty
	a_ack_len: assert property (p_ack_len) else $error("ack pulse length wrong");
	property p_pe_set;
		(i_fault[F_NO_PAPER] | i_fault[F_HEAD_UP])[*5] |-> o_pins.paper_err;
	endproperty
	a_pe_set: assert property (p_pe_set) else $error("paper error missing");
	property p_pe_clr;
		(i_fault[2:0] == 3'h0)[*5] |-> !o_pins.paper_err;
	endproperty
	a_pe_clr: assert property (p_pe_clr) else $error("paper error spurious");
	property p_err_set;
		(|i_fault[7:3])[*5] |-> !o_pins.err_n;
	endproperty
	a_err_set: assert property (p_err_set) else $error("error line missing");
	property p_err_clr;
		(i_fault[7:3] == 5'h00)[*5] |-> o_pins.err_n;
	endproperty
	a_err_clr: assert property (p_err_clr) else $error("error line spurious");
endmodule
bind parallel_byte_input_port par_port_chk par_port_chk_i (.i_mclk(i_mclk),
	.i_rst_n(i_rst_n), .i_strobe_n(i_strobe_n), .i_fault(i_fault), .o_pins(o_pins));
`default_nettype wire

// file: test/host_port_model.sv
// host side: drives data lines and strobe
`timescale 1ns/10ps
`default_nettype none
module host_port_model (
	// clock
	input wire logic i_mclk,
	// device status
	input wire par_port_pkg::port_pins_t i_pins,
	// host lines
	output logic o_strobe_n,
	output logic [7:0] o_data
);
	import par_port_pkg::*;
	initial begin
		o_strobe_n = 1'b1;
		o_data = 8'h00;
	end
	// polite = 0 strobes into a busy device on purpose
	task automatic send(input logic [7:0] b, input logic polite);
		int n;
		for (n = 0; n < 2000 && polite && i_pins.busy; n++) begin
			@(posedge i_mclk);
		end
		@(posedge i_mclk);
		o_data <= b;
		@(posedge i_mclk);
		o_strobe_n <= 1'b0;
		repeat (8) @(posedge i_mclk);
		o_strobe_n <= 1'b1;
		repeat (4) @(posedge i_mclk);
		// released lines float, so show the inverse
		o_data <= ~b;
	endtask
endmodule
`default_nettype wire

// file: test/parallel_byte_input_port_bench.sv
// self-checking bench for the parallel byte input port
`timescale 1ns/10ps
`default_nettype none
module parallel_byte_input_port_bench;
	import par_port_pkg::*;
	logic i_mclk, i_rst_n, i_strobe_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
	logic [7:0] i_data, i_fault;
	logic [4:0] i_awaddr, i_araddr;
	logic [31:0] i_wdata, o_rdata;
	logic [3:0] i_wstrb;
	logic [1:0] o_bresp, o_rresp;
	port_pins_t o_pins;
	int errors, checks;
	parallel_byte_input_port parallel_byte_input_port_i (.i_mclk, .i_rst_n, .i_strobe_n,
		.i_data, .o_pins, .i_fault, .o_irq, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid,
		.o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid,
		.o_arready, .i_araddr, .o_rvalid, .i_rready, .o_rdata, .o_rresp);
	host_port_model host_port_model_i (.i_mclk, .i_pins(o_pins), .o_strobe_n(i_strobe_n),
		.o_data(i_data));
	initial begin
		i_mclk = 1'b0;
		forever #12.5 i_mclk = ~i_mclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic conclude();
		$display("errors=%0d checks=%0d", errors, checks);
		if (errors == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic bail(input logic hit);
		if (hit) begin
			chk(32'h0000_0000, 32'h0000_0001, "wait ran out");
			conclude();
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		logic aw_rdy, w_rdy, b_v;
		logic [1:0] resp;
		b_v = 1'b0;
		resp = 2'h0;
		i_awvalid <= 1'b1;
		i_awaddr <= a;
		i_wvalid <= 1'b1;
		i_wdata <= d;
		i_bready <= 1'b1;
		// settled values taken mid-cycle stand at the next rising edge
		for (n = 0; n < 50; n++) begin
			@(negedge i_mclk);
			aw_rdy = o_awready & i_awvalid;
			w_rdy = o_wready & i_wvalid;
			b_v = o_bvalid;
			resp = o_bresp;
			@(posedge i_mclk);
			if (aw_rdy) i_awvalid <= 1'b0;
			if (w_rdy) i_wvalid <= 1'b0;
			if (b_v) break;
		end
		i_bready <= 1'b0;
		@(posedge i_mclk);
		bail(n == 50);
		chk(resp, r, "bresp");
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		logic ar_rdy, r_v;
		logic [31:0] data;
		logic [1:0] resp;
		r_v = 1'b0;
		data = 32'h0000_0000;
		resp = 2'h0;
		i_arvalid <= 1'b1;
		i_araddr <= a;
		i_rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(negedge i_mclk);
			ar_rdy = o_arready & i_arvalid;
			r_v = o_rvalid;
			data = o_rdata;
			resp = o_rresp;
			@(posedge i_mclk);
			if (ar_rdy) i_arvalid <= 1'b0;
			if (r_v) break;
		end
		i_rready <= 1'b0;
		@(posedge i_mclk);
		bail(n == 50);
		chk(data, d, "rdata");
		chk(resp, r, "rresp");
	endtask
	task automatic t_byte();
		int n;
		int m;
		wr({1'b1, ADDR_IRQ_EN}, 32'h0000_0001, RESP_OKAY);
		host_port_model_i.send(8'h4b, 1'b1);
		chk(o_pins.busy, 1'b1, "busy");
		rd({1'b0, ADDR_DATA}, 32'h0000_004b, RESP_OKAY);
		chk(o_irq, 1'b1, "irq");
		wr({1'b1, ADDR_IRQ_EN}, 32'h0000_0000, RESP_OKAY);
		rd({1'b1, ADDR_IRQ_EN}, 32'h0000_0000, RESP_OKAY);
		chk(o_irq, 1'b0, "masked irq");
		host_port_model_i.send(8'hb4, 1'b0);
		rd({1'b0, ADDR_DATA}, 32'h0000_004b, RESP_OKAY);
		rd({1'b1, ADDR_IRQ_STAT}, 32'h0000_0003, RESP_OKAY);
		wr({1'b1, ADDR_IRQ_CLR}, 32'h0000_0003, RESP_OKAY);
		rd({1'b1, ADDR_IRQ_STAT}, 32'h0000_0000, RESP_OKAY);
		chk(o_pins.busy, 1'b1, "busy held");
		// watch the pulse from its first low cycle while the write runs
		fork
			wr({1'b0, ADDR_CTRL}, 32'h0000_0002, RESP_OKAY);
			begin
				for (n = 0; n < 60 && o_pins.ack_n !== 1'b0; n++) @(negedge i_mclk);
				bail(n == 60);
				chk(o_pins.busy, 1'b0, "ready at ack");
				for (m = 0; m < 400 && o_pins.ack_n === 1'b0; m++) @(negedge i_mclk);
				chk(m, ACK_CYCLES, "ack width");
			end
		join
	endtask
	task automatic t_fault();
		int i;
		@(posedge i_mclk);
		for (i = 0; i < 8; i++) begin
			i_fault <= 8'h01 << i;
			repeat (5) @(posedge i_mclk);
			chk(o_pins.paper_err, i < 2, "paper err");
			chk(o_pins.err_n, i < 3, "err");
			rd({1'b0, ADDR_FAULT}, 32'h0000_0001 << i, RESP_OKAY);
		end
		i_fault <= 8'h04;
		wr({1'b0, ADDR_CTRL}, 32'h0000_000d, RESP_OKAY);
		repeat (5) @(posedge i_mclk);
		chk(o_pins, 6'h2f, "near end");
		rd({1'b0, ADDR_CTRL}, 32'h0000_000d, RESP_OKAY);
		wr({1'b0, ADDR_CTRL}, 32'h0000_0004, RESP_OKAY);
		repeat (5) @(posedge i_mclk);
		chk(o_pins, 6'h26, "status lines");
		i_fault <= 8'h00;
	endtask
	initial begin
		errors = 0;
		checks = 0;
		i_rst_n = 1'b0;
		i_fault = 8'h00;
		{i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
		{i_awaddr, i_araddr, i_wdata} = 42'h000_0000_0000;
		i_wstrb = 4'hf;
		repeat (2) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		@(posedge i_mclk);
		chk(o_pins, PINS_RST, "reset pins");
		rd({1'b0, ADDR_STAT}, 32'h0000_0024, RESP_OKAY);
		t_byte();
		t_fault();
		rd(5'h1c, 32'h0000_0000, RESP_SLVERR);
		wr(5'h1c, 32'h0000_0001, RESP_SLVERR);
		conclude();
	end
endmodule
`default_nettype wire
